// ### core/hpcr_pkg.sv
// Package for the hub port configuration register slice.
// Assumes a single 100 MHz core clock and a plain byte-wide register port.
package hpcr_pkg;
	localparam int NUM_PORTS = 4;
	localparam logic [7:0] CFG_OFFSET = 8'h08;
	localparam logic [7:0] FIXED_OFFSET = 8'h09;
	localparam logic [7:0] OFF_OFFSET = 8'h0a;
	localparam logic [7:0] STATUS_OFFSET = 8'h10;
	localparam logic [7:0] MAP_OFFSET = 8'h11;
	localparam int RENUM_BIT = 3;
	localparam int IND_LO = 1;
	localparam int STRING_BIT = 0;
	localparam logic [1:0] IND_SPEED = 2'h1;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'h0f;
	localparam logic [7:0] PORT_WMASK = 8'h1e;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [2:0] ZERO_COUNT = 3'h0;
endpackage : hpcr_pkg

// ### core/hpcr_cfg_if.sv
// Interface carrying the stored settings into the port mapping logic.
// Assumes both ends share the core clock domain.
`timescale 1ns/1ns
interface hpcr_cfg_if;
	logic renumber;
	logic [4:1] off_bits;
	logic [3:0] logical_port;
	logic [2:0] active_count;
	modport src (output renumber, output off_bits, input logical_port, input active_count);
	modport map (input renumber, input off_bits, output logical_port, output active_count);
endinterface : hpcr_cfg_if

// ### core/hpcr_port_map.sv
// Combinational logical port valid map and enabled port count; the renumber setting is not used here.
// Assumes settings are stable registers in the core clock domain.
`timescale 1ns/1ns
module hpcr_port_map (
	// Settings in, map out.
	hpcr_cfg_if.map cfg
);
	always_comb begin
		logic [2:0] cnt;
		cnt = 3'h0;
		cfg.logical_port = 4'h0;
		for (int i = 1; i <= hpcr_pkg::NUM_PORTS; i++) begin
			if (!cfg.off_bits[i]) begin
				cnt = cnt + 3'h1;
				cfg.logical_port[i - 1] = 1'b1;
			end
		end
		cfg.active_count = cnt;
	end
endmodule : hpcr_port_map

// ### core/hpcr_top.sv
// Top of the hub port configuration register slice.
// Assumes synchronous inputs on core_clk and a loader that writes before enumeration.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module hpcr_top (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Operating context.
	input wire logic use_default_cfg,
	input wire logic self_powered,
	input wire logic [1:0] fixed_attach_strap_pins,
	// Effects seen by the host side.
	output logic port_renumber_select,
	output logic [1:0] indicator_mode_select,
	output logic indicator_support,
	output logic string_enable,
	output logic [4:1] fixed_attach_ports,
	output logic [4:1] port_disabled,
	output logic [2:0] enabled_port_count,
	output logic [3:0] logical_port_valid
);
	////////////////////////////////////////////////////////////////////////////
	logic [7:0] cfg_byte, next_cfg_byte;
	logic [7:0] fixed_attach_bits, next_fixed_attach_bits;
	logic [7:0] self_powered_port_off_bits, next_self_powered_port_off_bits;
	logic [7:0] next_reg_rdata;
	logic [4:1] eff_fixed, eff_off;
	logic [4:1] next_fixed_out, next_off_out;
	logic [2:0] next_count;
	logic [3:0] next_valid;
	hpcr_cfg_if cfg_link ();

	hpcr_port_map u_map (
		.cfg(cfg_link.map)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register writes; reserved bits are never stored.
	always_comb begin
		next_cfg_byte = cfg_byte;
		next_fixed_attach_bits = fixed_attach_bits;
		next_self_powered_port_off_bits = self_powered_port_off_bits;
		if (reg_wr) begin
			unique case (reg_addr)
				hpcr_pkg::CFG_OFFSET: begin
					next_cfg_byte = reg_wdata & hpcr_pkg::CFG_WMASK;
				end
				hpcr_pkg::FIXED_OFFSET: begin
					next_fixed_attach_bits = reg_wdata & hpcr_pkg::PORT_WMASK;
				end
				hpcr_pkg::OFF_OFFSET: begin
					next_self_powered_port_off_bits = reg_wdata & hpcr_pkg::PORT_WMASK;
				end
				default: begin
				end
			endcase
		end
	end

	// Read data, valid in the cycle after the strobe; unmapped reads return zero.
	always_comb begin
		next_reg_rdata = hpcr_pkg::ZERO_BYTE;
		if (reg_rd) begin
			unique case (reg_addr)
				hpcr_pkg::CFG_OFFSET: next_reg_rdata = cfg_byte;
				hpcr_pkg::FIXED_OFFSET: next_reg_rdata = fixed_attach_bits;
				hpcr_pkg::OFF_OFFSET: next_reg_rdata = self_powered_port_off_bits;
				hpcr_pkg::STATUS_OFFSET: next_reg_rdata = {1'b0, enabled_port_count, port_disabled};
				hpcr_pkg::MAP_OFFSET: next_reg_rdata = {logical_port_valid, fixed_attach_ports};
				default: next_reg_rdata = hpcr_pkg::ZERO_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective port settings derived from the stored bytes; fixed-attach ports 2..1 come from the strap pins when use_default_cfg is set.
	always_comb begin
		if (use_default_cfg) begin
			eff_fixed = {2'b00, fixed_attach_strap_pins};
		end else begin
			eff_fixed = fixed_attach_bits[4:1];
		end
		if (self_powered && !cfg_byte[hpcr_pkg::RENUM_BIT]) begin
			eff_off = self_powered_port_off_bits[4:1];
		end else begin
			eff_off = 4'h0;
		end
		cfg_link.renumber = cfg_byte[hpcr_pkg::RENUM_BIT];
		cfg_link.off_bits = eff_off;
		next_off_out = eff_off;
		next_fixed_out = eff_fixed & ~eff_off;
		next_count = cfg_link.active_count;
		next_valid = cfg_link.logical_port;
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_byte <= hpcr_pkg::CFG_RESET;
			fixed_attach_bits <= hpcr_pkg::MASK_RESET;
			self_powered_port_off_bits <= hpcr_pkg::MASK_RESET;
			reg_rdata <= hpcr_pkg::ZERO_BYTE;
			port_renumber_select <= 1'b0;
			indicator_mode_select <= 2'b00;
			indicator_support <= 1'b0;
			string_enable <= 1'b0;
			fixed_attach_ports <= 4'h0;
			port_disabled <= 4'h0;
			enabled_port_count <= hpcr_pkg::ZERO_COUNT;
			logical_port_valid <= 4'h0;
		end else begin
			cfg_byte <= next_cfg_byte;
			fixed_attach_bits <= next_fixed_attach_bits;
			self_powered_port_off_bits <= next_self_powered_port_off_bits;
			reg_rdata <= next_reg_rdata;
			port_renumber_select <= next_cfg_byte[hpcr_pkg::RENUM_BIT];
			indicator_mode_select <= next_cfg_byte[hpcr_pkg::IND_LO +: 2];
			indicator_support <= (next_cfg_byte[hpcr_pkg::IND_LO +: 2] != hpcr_pkg::IND_SPEED);
			string_enable <= next_cfg_byte[hpcr_pkg::STRING_BIT];
			fixed_attach_ports <= next_fixed_out;
			port_disabled <= next_off_out;
			enabled_port_count <= next_count;
			logical_port_valid <= next_valid;
		end
	end
endmodule : hpcr_top

// ### tb/hpcr_sva.sv
// Checker for the hub port configuration register slice.
// Assumes it is bound to hpcr_top and sees only its ports.
`timescale 1ns/1ns
module hpcr_sva (
	// Ports of the top module.
	input wire logic core_clk, input wire logic rst_n, input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata, input wire logic reg_wr, input wire logic reg_rd,
	input wire logic [7:0] reg_rdata, input wire logic self_powered,
	input wire logic port_renumber_select, input wire logic [1:0] indicator_mode_select,
	input wire logic indicator_support, input wire logic string_enable,
	input wire logic [4:1] port_disabled, input wire logic [2:0] enabled_port_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic cw;
	assign cw = reg_wr && reg_addr == 8'h08;
	a_renum_follow: assert property (cw |=> port_renumber_select == $past(reg_wdata[3]))
		else $error("renumber select wrong");
	a_mode_follow: assert property (cw |=> indicator_mode_select == $past(reg_wdata[2:1]))
		else $error("indicator mode wrong");
	a_support_report: assert property (cw |=> indicator_support == ($past(reg_wdata[2:1]) != 2'h1))
		else $error("indicator support wrong");
	a_string_gate: assert property (cw |=> string_enable == $past(reg_wdata[0]))
		else $error("string enable wrong");
	a_fixed_resv: assert property (reg_rd && reg_addr == 8'h09 |=> (reg_rdata & 8'he1) == 8'h00)
		else $error("reserved bits read nonzero");
	a_count_match: assert property ($past(rst_n) |-> enabled_port_count == 3'(4 - $countones(port_disabled)))
		else $error("enabled count wrong");
	a_remap_clear: assert property (port_renumber_select || !self_powered |=> port_disabled == 4'h0)
		else $error("port disabled outside self powered standard mode");
	a_off_bits: assert property (reg_wr && reg_addr == 8'h0a && self_powered && !port_renumber_select ##1 self_powered && !port_renumber_select |=> port_disabled == $past(reg_wdata[4:1], 2))
		else $error("disabled ports differ from mask");
endmodule : hpcr_sva
bind hpcr_top hpcr_sva hpcr_sva_i (.*);

// ### tb/hpcr_loader.sv
// Model of the configuration loader driving the register port.
// Assumes its tasks are called from one process on core_clk.
`timescale 1ns/1ns
module hpcr_loader (
	// Register port, master side.
	input wire logic core_clk, input wire logic [7:0] reg_rdata, output logic reg_wr,
	output logic reg_rd, output logic [7:0] reg_addr, output logic [7:0] reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
	// Writes the given byte to the given offset with a one-cycle write strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge core_clk);
		{reg_rd, reg_addr} <= {1'b0, ~a};
		#1 d = reg_rdata;
	endtask : rd
endmodule : hpcr_loader

// ### tb/tb_top.sv
// Testbench for the hub port configuration register slice.
// Assumes hpcr_top, its checker and the loader model are compiled first.
`timescale 1ns/1ns
module tb_top;
	logic core_clk, rst_n, use_default_cfg, self_powered, reg_wr, reg_rd;
	logic port_renumber_select, indicator_support, string_enable;
	logic [1:0] fixed_attach_strap_pins, indicator_mode_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, m;
	logic [4:1] fixed_attach_ports, port_disabled;
	logic [2:0] enabled_port_count;
	logic [3:0] logical_port_valid;
	int n_errors = 0;
	int check_count = 0;
	hpcr_top hpcr_top_i (.*);
	hpcr_loader hpcr_loader_i (.*);
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic t_cfg();
		for (int i = 0; i < 16; i++) begin
			hpcr_loader_i.wr(8'h08, 8'hf0 | 8'(i));
			hpcr_loader_i.rd(8'h08, rd_val);
			chk("cfg", rd_val, 8'(i));
			chk("renum", 8'(port_renumber_select), 8'(i >> 3));
			chk("mode", 8'(indicator_mode_select), 8'((i >> 1) & 3));
			chk("support", 8'(indicator_support), 8'(((i >> 1) & 3) != 1));
			chk("string", 8'(string_enable), 8'(i & 1));
		end
		$display("t_cfg done");
	endtask : t_cfg
	task automatic t_masks();
		hpcr_loader_i.wr(8'h08, 8'h00);
		hpcr_loader_i.wr(8'h09, 8'hff);
		hpcr_loader_i.rd(8'h09, rd_val);
		chk("fixed rd", rd_val, 8'h1e);
		for (int k = 0; k < 3; k++) begin
			m = (k == 0) ? 8'hff : (k == 1) ? 8'h14 : 8'h0b;
			hpcr_loader_i.wr(8'h0a, m);
			hpcr_loader_i.rd(8'h0a, rd_val);
			chk("off rd", rd_val, m & 8'h1e);
			chk("off", 8'(port_disabled), 8'(m[4:1]));
			chk("count", 8'(enabled_port_count), 8'(4 - $countones(m[4:1])));
			chk("valid", 8'(logical_port_valid), {4'h0, ~m[4:1]});
			chk("fixed", 8'(fixed_attach_ports), {4'h0, ~m[4:1]});
		end
		hpcr_loader_i.wr(8'h10, 8'hff);
		hpcr_loader_i.rd(8'h10, rd_val);
		chk("status rd", rd_val, 8'h25);
		hpcr_loader_i.rd(8'h11, rd_val);
		chk("map rd", rd_val, 8'haa);
		hpcr_loader_i.wr(8'h08, 8'h08);
		hpcr_loader_i.rd(8'h30, rd_val);
		chk("unmapped", rd_val, 8'h00);
		chk("remap", 8'(port_disabled), 8'h00);
		hpcr_loader_i.wr(8'h08, 8'h00);
		@(posedge core_clk) self_powered <= 1'b0;
		hpcr_loader_i.rd(8'h0a, rd_val);
		chk("bus pwr", 8'(port_disabled), 8'h00);
		$display("t_masks done");
	endtask : t_masks
	task automatic t_straps();
		@(posedge core_clk) use_default_cfg <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			@(posedge core_clk) fixed_attach_strap_pins <= 2'(s);
			hpcr_loader_i.rd(8'h09, rd_val);
			chk("strap", 8'(fixed_attach_ports), 8'(s));
		end
		$display("t_straps done");
	endtask : t_straps
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#20000;
		n_errors++;
		close_out();
	end
	initial begin
		{rst_n, use_default_cfg, self_powered, fixed_attach_strap_pins} = 5'h04;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		t_cfg();
		t_masks();
		t_straps();
		close_out();
	end
endmodule : tb_top
